// ### logic/cfc_pkg.sv
// Shared constants and types for the carriage form control block
package cfc_pkg;
  localparam int NSK = 11;
  localparam int NHOLE = 12;
  localparam int NST = 4;
  localparam int CH_HOME = 0;
  localparam int CH_OVF = 11;
  localparam logic [NSK-1:0] BASE_CH_MASK = 11'h03F;
  localparam int DW = 32;
  localparam int AW = 3;
  localparam logic [AW-1:0] A_CTRL = 3'h0;
  localparam logic [AW-1:0] A_STAT = 3'h1;
  localparam logic [AW-1:0] A_MASK = 3'h2;
  localparam logic [AW-1:0] A_STATE = 3'h3;
  localparam logic [AW-1:0] A_SKIP = 3'h4;
  localparam int C_SPC = 0;
  localparam int C_EXT = 2;
  localparam int C_SEQ = 3;
  localparam logic [1:0] SPC_RST = 2'h1;
  localparam logic EXT_RST = 1'b0;
  localparam logic [1:0] SEQ_RST = 2'h0;
  localparam logic [NST-1:0] MASK_RST = 4'h0;
  localparam int ST_OVF = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_LINE = 2;
  localparam int ST_STOP = 3;
  localparam int F_PEND = 0;
  localparam int F_READY = 11;
  localparam int F_FEED = 12;
  localparam int F_LINE = 13;
  localparam int P_SKIP = 0;
  localparam int P_HOLE = 11;
  localparam int P_REST = 23;
  localparam int P_STOP = 24;
  localparam int P_RPT = 25;
  localparam int P_STRT = 26;
  localparam int P_CLU = 27;
  localparam int P_PCMD = 28;
  localparam int P_STEP = 29;
  localparam int P_DONE = 30;
  localparam int P_ERR = 31;
  localparam int P_FMT = 32;
  localparam int PIN_W = 36;
  typedef enum logic [2:0] {
    S_IDLE, S_PRESKIP, S_SPACE, S_PRINT, S_POSTSKIP, S_RESTORE
  } cfc_state_t;
endpackage

// ### logic/cfc_pend_if.sv
// Pending skip flag bundle between sequencer and flag store
`timescale 1ns/1ps
interface cfc_pend_if;
  logic [cfc_pkg::NSK-1:0] set;
  logic [cfc_pkg::NSK-1:0] hole;
  logic [cfc_pkg::NSK-1:0] pend;
  logic flush;
  logic any;
  modport owner (input set, input hole, input flush, output pend,
    output any);
  modport user (output set, output hole, output flush, input pend,
    input any);
endinterface

// ### logic/cfc_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module cfc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule

// ### logic/cfc_pend.sv
// Per-channel pending skip flags
`timescale 1ns/1ps
module cfc_pend (
  input wire logic clk,
  input wire logic rst_b,
  cfc_pend_if.owner p
);
  import cfc_pkg::*;
  logic [NSK-1:0] flag_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= '0;
    end else if (p.flush) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~p.hole) | p.set;
    end
  end

  assign p.pend = flag_q;
  assign p.any = |flag_q;
endmodule

// ### logic/cfc_top.sv
// Carriage form control: skip, spacing, overflow and operator keys
//
// Summary of operation
// - Restore with tractor free returns tape home, acting on key release.
// - Stop halts carriage at once; printing halts after current line.
// - Each reprint press starts exactly one print cycle from buffer.
// - Reprint clears ready; only start control sets ready again.
// - After error stop, reprint prints next sequence line, then wraps.
// - Skip feeds until its channel hole; channels 7-11 optional.
// - Skip before print command precedes print; later skips follow it.
// - Several skips: no precedence, feed until every channel sensed.
// - Channel 12 hole during analysis emits an overflow pulse.
// - Overflow line still prints; only the next cycle is affected.
// - Spacing selection advances zero, one, two or three lines.
// - Selected spacing happens once just before each line prints.
// - Skips come from analyzer outputs or processor impulses.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cfc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [cfc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cfc_pkg::DW-1:0] avs_writedata,
  output logic [cfc_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [cfc_pkg::NSK-1:0] skip_channel_request,
  input wire logic [cfc_pkg::NHOLE-1:0] tape_hole,
  input wire logic restore_key,
  input wire logic stop_key,
  input wire logic reprint_key,
  input wire logic start_key,
  input wire logic clutch_disengaged,
  input wire logic print_cmd,
  input wire logic feed_step,
  input wire logic print_line_done,
  input wire logic error_stop,
  input wire logic [3:0] format_analyzer_outputs,
  output logic feed_motor,
  output logic print_start,
  output logic overflow_pulse,
  output logic printer_ready,
  output logic [1:0] multi_line_sequence_line,
  output logic irq
);
  import cfc_pkg::*;

  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] syn;
  logic [PIN_W-1:0] prev_q;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;
  logic [NHOLE-1:0] hole_r;
  logic [NSK-1:0] req;
  logic [NSK-1:0] sw_skip;
  logic [NSK-1:0] ch_mask;
  cfc_state_t state_q;
  logic stop_go;
  logic restore_go;
  logic print_go;
  logic rpt_go;
  logic pre_phase;
  logic run_q;
  logic manual_q;
  logic more_q;
  logic stop_q;
  logic [1:0] line_q;
  logic [1:0] seq_line_q;
  logic [1:0] sp_need_q;
  logic [1:0] sp_cnt_q;
  logic [1:0] sp_sel;
  logic feed_want;
  logic feed_q;
  logic pstart_q;
  logic ovf_q;
  logic ready_q;
  logic pre_any_q;
  logic post_any_q;
  logic [1:0] spc_def_q;
  logic ext_q;
  logic [1:0] seq_last_q;
  logic [NST-1:0] stat_q;
  logic [NST-1:0] mask_q;
  logic [NST-1:0] stat_set;
  logic [NST-1:0] stat_clr;
  logic irq_q;
  logic wait_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rd_mux;
  logic bus_req;
  logic bus_done;
  logic wr_go;

  cfc_pend_if pre_if ();
  cfc_pend_if post_if ();

  assign raw = {format_analyzer_outputs, error_stop, print_line_done,
    feed_step, print_cmd, clutch_disengaged, start_key, reprint_key,
    stop_key, restore_key, tape_hole, skip_channel_request};

  cfc_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(raw),
    .sync_q(syn)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= '0;
    end else begin
      prev_q <= syn;
    end
  end

  assign rise = syn & ~prev_q;
  assign fall = ~syn & prev_q;
  assign hole_r = rise[P_HOLE +: NHOLE];
  assign stop_go = rise[P_STOP];
  // act on key release, tractor disengaged
  assign restore_go = fall[P_REST] & syn[P_CLU];
  assign print_go = rise[P_PCMD] & ready_q;
  assign rpt_go = rise[P_RPT];

  // channels 7-11 only with extension enabled
  assign ch_mask = ext_q ? {NSK{1'b1}} : BASE_CH_MASK;
  // pins and processor writes both request skips
  assign req = (rise[P_SKIP +: NSK] | sw_skip) & ch_mask;

  // requests during a print cycle are deferred past printing
  assign pre_phase = (state_q == S_IDLE) || (state_q == S_PRESKIP) ||
    (state_q == S_RESTORE);
  assign pre_if.set = pre_phase ? req : '0;
  assign post_if.set = pre_phase ? '0 : req;
  // every sensed channel retires only its own flag
  assign pre_if.hole = (state_q == S_PRESKIP) ? hole_r[NSK-1:0] : '0;
  assign post_if.hole = (state_q == S_POSTSKIP) ? hole_r[NSK-1:0] : '0;
  assign pre_if.flush = stop_go;
  assign post_if.flush = stop_go;

  cfc_pend u_pre (.clk(clk), .rst_b(rst_b), .p(pre_if));
  cfc_pend u_post (.clk(clk), .rst_b(rst_b), .p(post_if));

  always_comb begin
    if (syn[P_FMT+3]) begin
      sp_sel = 2'h0;
    end else if (syn[P_FMT+2]) begin
      sp_sel = 2'h3;
    end else if (syn[P_FMT+1]) begin
      sp_sel = 2'h2;
    end else if (syn[P_FMT]) begin
      sp_sel = 2'h1;
    end else begin
      sp_sel = spc_def_q;
    end
  end

  // Print requests wait in run_q until a cycle starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      manual_q <= 1'b0;
    end else begin
      // one reprint press, one pending cycle
      run_q <= (run_q & (state_q != S_SPACE) & ~stop_go) | print_go |
        rpt_go;
      if (rpt_go) begin
        manual_q <= 1'b1;
      end else if (print_go) begin
        manual_q <= 1'b0;
      end
    end
  end

  // Main sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      sp_need_q <= 2'h0;
      sp_cnt_q <= 2'h0;
      line_q <= 2'h0;
      seq_line_q <= 2'h0;
      more_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (print_go) begin
        line_q <= 2'h0;
      end
      if (stop_go) begin
        stop_q <= 1'b1;
        more_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          stop_q <= 1'b0;
          if (restore_go) begin
            state_q <= S_RESTORE;
          end else if (pre_if.any) begin
            state_q <= S_PRESKIP;
          end else if (run_q) begin
            state_q <= S_SPACE;
            sp_need_q <= sp_sel;
            sp_cnt_q <= 2'h0;
          end
        end
        S_PRESKIP: begin
          if (stop_go || !pre_if.any) begin
            state_q <= S_IDLE;
          end
        end
        S_SPACE: begin
          if (stop_go) begin
            state_q <= S_IDLE;
          end else if (sp_cnt_q == sp_need_q) begin
            state_q <= S_PRINT;
            seq_line_q <= line_q;
          end else if (rise[P_STEP]) begin
            sp_cnt_q <= sp_cnt_q + 2'h1;
          end
        end
        S_PRINT: begin
          // the line in progress always completes
          // overflow never cuts the current line short
          if (rise[P_DONE]) begin
            state_q <= S_POSTSKIP;
            // advance through the sequence, wrap after last
            line_q <= (line_q == seq_last_q) ? 2'h0 : line_q + 2'h1;
            more_q <= ~manual_q & ~syn[P_ERR] & ~stop_q & ~stop_go &
              (line_q != seq_last_q);
          end
        end
        S_POSTSKIP: begin
          if (stop_q || stop_go) begin
            state_q <= S_IDLE;
          end else if (!post_if.any) begin
            if (more_q) begin
              state_q <= S_SPACE;
              sp_need_q <= sp_sel;
              sp_cnt_q <= 2'h0;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_RESTORE: begin
          if (stop_go || hole_r[CH_HOME]) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // feed while any active flag stands
  always_comb begin
    case (state_q)
      S_PRESKIP: feed_want = pre_if.any;
      S_POSTSKIP: feed_want = post_if.any & ~stop_q;
      S_SPACE: feed_want = sp_cnt_q != sp_need_q;
      S_RESTORE: feed_want = 1'b1;
      S_IDLE: feed_want = syn[P_REST] & ~syn[P_CLU];
      default: feed_want = 1'b0;
    endcase
  end

  // Carriage and print outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feed_q <= 1'b0;
      pstart_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      // motor off on the edge after stop
      feed_q <= feed_want & ~stop_go;
      pstart_q <= (state_q == S_SPACE) & ~stop_go &
        (sp_cnt_q == sp_need_q);
      ovf_q <= (state_q == S_SPACE) & hole_r[CH_OVF];
    end
  end

  // ready cleared by reprint or stop, set by start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_q <= 1'b0;
    end else if (rise[P_STRT]) begin
      ready_q <= 1'b1;
    end else if (rpt_go || stop_go) begin
      ready_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_any_q <= 1'b0;
      post_any_q <= 1'b0;
    end else begin
      pre_any_q <= pre_if.any;
      post_any_q <= post_if.any;
    end
  end

  assign stat_set[ST_OVF] = ovf_q;
  assign stat_set[ST_SKIP] = (pre_any_q & ~pre_if.any) |
    (post_any_q & ~post_if.any);
  assign stat_set[ST_LINE] = (state_q == S_PRINT) & rise[P_DONE];
  assign stat_set[ST_STOP] = stop_go;

  // Avalon slave: one wait cycle per access
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~wait_q;
  assign wr_go = bus_done & avs_write;
  assign stat_clr = (bus_done && avs_read && avs_address == A_STAT) ?
    rdata_q[NST-1:0] : '0;
  assign sw_skip = (wr_go && avs_address == A_SKIP) ?
    avs_writedata[NSK-1:0] : '0;

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      A_CTRL: begin
        rd_mux[C_SPC +: 2] = spc_def_q;
        rd_mux[C_EXT] = ext_q;
        rd_mux[C_SEQ +: 2] = seq_last_q;
      end
      A_STAT: rd_mux[NST-1:0] = stat_q;
      A_MASK: rd_mux[NST-1:0] = mask_q;
      A_STATE: begin
        rd_mux[F_PEND +: NSK] = pre_if.pend | post_if.pend;
        rd_mux[F_READY] = ready_q;
        rd_mux[F_FEED] = feed_q;
        rd_mux[F_LINE +: 2] = line_q;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spc_def_q <= SPC_RST;
      ext_q <= EXT_RST;
      seq_last_q <= SEQ_RST;
      mask_q <= MASK_RST;
    end else if (wr_go && avs_address == A_CTRL) begin
      spc_def_q <= avs_writedata[C_SPC +: 2];
      ext_q <= avs_writedata[C_EXT];
      seq_last_q <= avs_writedata[C_SEQ +: 2];
    end else if (wr_go && avs_address == A_MASK) begin
      mask_q <= avs_writedata[NST-1:0];
    end
  end

  // Sticky status, set wins over read clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign feed_motor = feed_q;
  assign print_start = pstart_q;
  assign overflow_pulse = ovf_q;
  assign printer_ready = ready_q;
  assign multi_line_sequence_line = seq_line_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  restore_release_a: assert property (
    state_q == S_IDLE && restore_go |=> state_q == S_RESTORE ##1 feed_q)
    else $error("restore not started on key release");
  stop_motion_a: assert property (
    stop_go |=> !feed_q)
    else $error("carriage still feeding after stop");
  reprint_cycle_a: assert property (
    rpt_go && state_q == S_IDLE && !pre_if.any && !restore_go &&
    !stop_go |=> ##1 state_q == S_SPACE)
    else $error("reprint did not start a print cycle");
  ready_drop_a: assert property (
    rpt_go && !rise[P_STRT] |=> !ready_q)
    else $error("reprint left printer ready");
  ready_source_a: assert property (
    $rose(ready_q) |-> $past(rise[P_STRT]))
    else $error("ready set without start control");
  seq_wrap_a: assert property (
    state_q == S_PRINT && rise[P_DONE] && line_q == seq_last_q
    |=> line_q == 2'h0)
    else $error("sequence did not wrap after last line");
  defer_skip_a: assert property (
    (state_q == S_SPACE || state_q == S_PRINT) && req != '0 && !stop_go
    |-> pre_if.set == '0 ##1 (post_if.pend & $past(req)) == $past(req))
    else $error("skip during print cycle not deferred");
  skip_feed_a: assert property (
    state_q == S_PRESKIP && pre_if.any && !stop_go
    |=> feed_q && state_q == S_PRESKIP)
    else $error("pending skip not feeding");
  overflow_cause_a: assert property (
    overflow_pulse |-> $past(state_q == S_SPACE && hole_r[CH_OVF]))
    else $error("overflow pulse without channel 12 in analysis");
  space_before_a: assert property (
    print_start |-> $past(sp_cnt_q == sp_need_q) ##1 state_q == S_PRINT)
    else $error("print started before spacing done");
  stop_flush_a: assert property (
    stop_go |=> !pre_if.any && !post_if.any)
    else $error("pending skips survive stop");

  cover property (state_q == S_POSTSKIP && post_if.any);
  cover property (overflow_pulse);
  cover property (state_q == S_RESTORE ##[1:1000] state_q == S_IDLE);
  cover property (seq_line_q == 2'h2 && print_start);
endmodule

// ### tb/cfc_carriage.sv
// Carriage tape loop and print mechanism model
`timescale 1ns/1ps
module cfc_carriage (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic feed_motor,
  input wire logic print_start,
  output logic feed_step,
  output logic [11:0] tape_hole,
  output logic print_line_done,
  output logic [4:0] pos
);
  logic [3:0] cnt_q;
  logic [3:0] pr_q;
  // Punched channels per line of a 24-line loop
  always_comb begin
    case (pos)
      5'h00: tape_hole = 12'h001;
      5'h06: tape_hole = 12'h002;
      5'h0C: tape_hole = 12'h010;
      5'h14: tape_hole = 12'h040;
      5'h15: tape_hole = 12'h800;
      default: tape_hole = 12'h000;
    endcase
  end
  // One line every 16 motor cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      pos <= 5'h00;
      feed_step <= 1'b0;
    end else begin
      cnt_q <= feed_motor ? cnt_q + 4'h1 : 4'h0;
      feed_step <= feed_motor && cnt_q >= 4'hA;
      if (feed_motor && cnt_q == 4'hA)
        pos <= (pos == 5'h17) ? 5'h00 : pos + 5'h01;
    end
  end
  // Line finishes a few cycles after it starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pr_q <= 4'h0;
      print_line_done <= 1'b0;
    end else begin
      if (print_start)
        pr_q <= 4'h1;
      else if (pr_q != 4'h0)
        pr_q <= pr_q + 4'h1;
      print_line_done <= pr_q >= 4'hA;
    end
  end
endmodule

// ### tb/cfc_top_test.sv
// Self-checking bench for the carriage form control block
`timescale 1ns/1ps
module cfc_top_test;
  import cfc_pkg::*;
  logic clk;
  logic rst_b = 1'b0;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DW-1:0] avs_writedata = '0;
  logic [DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [NSK-1:0] skip_pin = '0;
  logic [NHOLE-1:0] tape_hole;
  logic [4:0] keys = '0;
  logic clutch = 1'b0;
  logic feed_step;
  logic line_done;
  logic error_stop = 1'b0;
  logic [3:0] fao = 4'h0;
  logic feed_motor;
  logic print_start;
  logic overflow_pulse;
  logic printer_ready;
  logic [1:0] seq_line;
  logic irq;
  logic [4:0] pos;
  logic [4:0] pr_pos;
  logic [1:0] pr_line;
  logic [DW-1:0] rd;
  int n_pr = 0;
  int n_ovf = 0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int p0;

  cfc_top u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .skip_channel_request(skip_pin),
    .tape_hole(tape_hole),
    .restore_key(keys[4]),
    .stop_key(keys[3]),
    .reprint_key(keys[2]),
    .start_key(keys[1]),
    .clutch_disengaged(clutch),
    .print_cmd(keys[0]),
    .feed_step(feed_step),
    .print_line_done(line_done),
    .error_stop(error_stop),
    .format_analyzer_outputs(fao),
    .feed_motor(feed_motor),
    .print_start(print_start),
    .overflow_pulse(overflow_pulse),
    .printer_ready(printer_ready),
    .multi_line_sequence_line(seq_line),
    .irq(irq)
  );

  cfc_carriage u_carriage (
    .clk(clk),
    .rst_b(rst_b),
    .feed_motor(feed_motor),
    .print_start(print_start),
    .feed_step(feed_step),
    .tape_hole(tape_hole),
    .print_line_done(line_done),
    .pos(pos)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (print_start === 1'b1) begin
      pr_pos <= pos;
      pr_line <= seq_line;
      n_pr <= n_pr + 1;
    end
    if (overflow_pulse === 1'b1)
      n_ovf <= n_ovf + 1;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (t >= 50)
      chk(32'h1, 32'h0);
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic press(input int i, input int hold);
    @(posedge clk);
    keys[i] <= 1'b1;
    repeat (hold) @(posedge clk);
    keys[i] <= 1'b0;
  endtask

  task automatic skip(input logic [NSK-1:0] m);
    @(posedge clk);
    skip_pin <= m;
    repeat (6) @(posedge clk);
    skip_pin <= '0;
  endtask

  // Wait until the carriage has been still for a while
  task automatic settle();
    int q;
    int t;
    q = 0;
    t = 0;
    while (q < 40 && t < 4000) begin
      @(posedge clk);
      t++;
      q = (feed_motor === 1'b0) ? q + 1 : 0;
    end
    if (t >= 4000)
      chk(32'h1, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rchk(A_CTRL, 32'h1);
    rchk(A_MASK, 32'h0);
    rchk(A_STATE, 32'h0);
    rchk(3'h5, 32'h0);
    bus(1'b1, 3'h6, 32'hFFFF_FFFF);
    rchk(A_CTRL, 32'h1);
    press(1, 6);
    repeat (6) @(posedge clk);
    chk(32'(printer_ready), 32'h1);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, A_CTRL, s);
      p0 = pos;
      press(0, 6);
      settle();
      chk(32'(pr_pos), 32'((p0 + s) % 24));
      chk(32'(pos), 32'(pr_pos));
    end
    for (int i = 0; i < 4; i++) begin
      fao <= 4'h1 << i;
      p0 = pos;
      press(0, 6);
      settle();
      chk(32'(pr_pos), 32'((p0 + (i + 1) % 4) % 24));
    end
    fao <= 4'h0;
    bus(1'b1, A_CTRL, 32'h1);
    skip(11'h002);
    press(0, 6);
    settle();
    chk(32'(pr_pos), 32'h7);
    press(0, 6);
    skip(11'h010);
    settle();
    chk(32'(pr_pos), 32'h8);
    chk(32'(pos), 32'hC);
    bus(1'b1, A_SKIP, 32'h012);
    repeat (20) @(posedge clk);
    rchk(A_STATE, 32'h1812);
    settle();
    chk(32'(pos), 32'hC);
    rchk(A_STATE, 32'h800);
    bus(1'b1, A_SKIP, 32'h040);
    repeat (8) @(posedge clk);
    rchk(A_STATE, 32'h800);
    bus(1'b1, A_CTRL, 32'h5);
    skip(11'h040);
    settle();
    chk(32'(pos), 32'h14);
    chk(32'(irq), 32'h0);
    bus(1'b0, A_STAT, 32'h0);
    bus(1'b1, A_MASK, 32'h1);
    p0 = n_ovf;
    press(0, 6);
    settle();
    chk(n_ovf, p0 + 1);
    chk(32'(pr_pos), 32'h15);
    chk(32'(irq), 32'h1);
    rchk(A_STAT, 32'h5);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    rchk(A_STAT, 32'h0);
    bus(1'b1, A_CTRL, 32'h10);
    error_stop <= 1'b1;
    p0 = n_pr;
    press(0, 6);
    settle();
    chk(n_pr, p0 + 1);
    chk(32'(pr_line), 32'h0);
    for (int i = 1; i < 5; i++) begin
      press(2, 6);
      settle();
      chk(32'(printer_ready), 32'h0);
      chk(n_pr, p0 + 1 + i);
      chk(32'(pr_line), 32'(i % 3));
    end
    press(0, 6);
    settle();
    chk(n_pr, p0 + 5);
    press(1, 6);
    repeat (6) @(posedge clk);
    chk(32'(printer_ready), 32'h1);
    error_stop <= 1'b0;
    bus(1'b1, A_SKIP, 32'h004);
    repeat (60) @(posedge clk);
    chk(32'(feed_motor), 32'h1);
    press(3, 8);
    chk(32'(feed_motor), 32'h0);
    bus(1'b0, A_STATE, 32'h0);
    chk(rd & 32'h17FF, 32'h0);
    @(posedge clk);
    keys[4] <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(feed_motor), 32'h1);
    keys[4] <= 1'b0;
    settle();
    clutch <= 1'b1;
    @(posedge clk);
    keys[4] <= 1'b1;
    repeat (40) @(posedge clk);
    chk(32'(feed_motor), 32'h0);
    keys[4] <= 1'b0;
    settle();
    chk(32'(pos), 32'h0);
    clutch <= 1'b0;
    close_out();
  end
endmodule
